// *** common/gpio_abc_pkg.sv ***
// Purpose: Shared constants and types for the port A/B/C block
// Assumes: Word-aligned register slots on AHB-Lite
// Notes:   Register slot byte address is four times its index

package gpio_abc_pkg;
    // ************************************************
    // Port widths
    // ************************************************
    localparam int unsigned PA_W = 8;
    localparam int unsigned PB_W = 8;
    localparam int unsigned PC_W = 6;

    // ************************************************
    // Register indices
    // ************************************************
    localparam logic [3:0] IDX_PA_DATA = 4'h0;
    localparam logic [3:0] IDX_PB_DATA = 4'h1;
    localparam logic [3:0] IDX_PC_DATA = 4'h2;
    localparam logic [3:0] IDX_PA_DIR  = 4'h4;
    localparam logic [3:0] IDX_PB_DIR  = 4'h5;
    localparam logic [3:0] IDX_PC_DIR  = 4'h6;
    localparam logic [3:0] IDX_NONE    = 4'hf;

    // ************************************************
    // Address decode and field positions
    // ************************************************
    localparam int unsigned IDX_LSB     = 2;
    localparam int unsigned IDX_MSB     = 5;
    localparam int unsigned MAP_HI_LSB  = 6;
    localparam int unsigned CLK_EN_BIT  = 7;
    localparam int unsigned PC_CLK_PIN  = 2;
    localparam int unsigned CHAN_W      = 5;
    localparam logic [4:0]  CHAN_COUNT  = 5'h08;
    localparam logic [7:0]  DIR_RESET   = 8'h00;
    localparam logic [1:0]  HRESP_OKAY  = 2'h0;

    // ************************************************
    // Captured address phase
    // ************************************************
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [3:0] idx;
    } bus_req_t;
endpackage : gpio_abc_pkg

// *** src/gpio_ports_abc.sv ***
// Purpose: Ports A, B and C with AHB-Lite register access
// Assumes: Single AHB-Lite slave, word transfers, pins synchronous
// Notes:   Reads take one wait state, writes none
//
// Contract
// - Port A has eight bidirectional pins, each with a latch bit.
// - Port data latches keep their contents through reset.
// - Direction one drives latch on pin; zero leaves pin high impedance.
// - Reset clears port A and B direction bits; pins become inputs.
// - Data read gives latch for output pins, pin level for inputs.
// - Data writes always update the latch, whatever the direction.
// - Writing an input pin's data changes only the latch, not readback.
// - Port B has eight pins doubling as analog channels.
// - Analog-selected port B pin is forced input, overriding port controls.
// - Unselected port B pins behave as ordinary digital pins.
// - Port C has six pins, each with latch and direction bit.
// - Clock output enable drives core_clk divided by two on port C pin two.
// - Clock output enable is read/write and cleared by reset.
// - Reset clears the six port C direction bits.
// - Port C data read mixes latch and pin at its own address; pin two reads zero while clock output is enabled.

`timescale 1ns/1ns

module gpio_ports_abc (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Analog converter channel select
    input  wire logic [4:0]  analog_chan_sel,
    // Port A pins
    input  wire logic [7:0]  pa_in,
    output logic      [7:0]  pa_out,
    output logic      [7:0]  pa_oe_n,
    // Port B pins
    input  wire logic [7:0]  pb_in,
    output logic      [7:0]  pb_out,
    output logic      [7:0]  pb_oe_n,
    // Port C pins
    input  wire logic [5:0]  pc_in,
    output logic      [5:0]  pc_out,
    output logic      [5:0]  pc_oe_n
);
    localparam int unsigned AW = gpio_abc_pkg::PA_W;
    localparam int unsigned BW = gpio_abc_pkg::PB_W;
    localparam int unsigned CW = gpio_abc_pkg::PC_W;

    gpio_abc_pkg::bus_req_t req_r;
    gpio_abc_pkg::bus_req_t req_nxt;
    logic          hready_r;
    logic          hready_nxt;
    logic [31:0]   hrdata_r;
    logic [31:0]   hrdata_nxt;
    logic          clk_en_r;
    logic          clk_en_nxt;
    logic          clk_div_r;
    logic          clk_div_nxt;
    logic          acc;
    logic          mapped;
    logic          wr_ok;
    logic          rd_done;
    logic [31:0]   rd_mux;
    logic [AW-1:0] a_latch;
    logic [AW-1:0] a_dir;
    logic [AW-1:0] a_rd;
    logic [BW-1:0] b_latch;
    logic [BW-1:0] b_dir;
    logic [BW-1:0] b_rd;
    logic [BW-1:0] b_hiz;
    logic [CW-1:0] c_latch;
    logic [CW-1:0] c_dir;
    logic [CW-1:0] c_rd;
    logic [CW-1:0] c_rd_mask;
    logic [CW-1:0] c_alt_en;
    logic [CW-1:0] c_alt_val;

    // ************************************************
    // Bus address phase and read answer
    // ************************************************
    always_comb begin
        acc     = hsel & htrans[1] & hready;
        mapped  = haddr[31:gpio_abc_pkg::MAP_HI_LSB] == '0;
        req_nxt = '0;
        if (acc) begin
            req_nxt.valid = 1'b1;
            req_nxt.write = hwrite;
            req_nxt.idx   = mapped ? haddr[gpio_abc_pkg::IDX_MSB:gpio_abc_pkg::IDX_LSB] : gpio_abc_pkg::IDX_NONE;
        end else if (!hready_r) begin
            req_nxt = req_r;
        end
        wr_ok   = req_r.valid & req_r.write & ~sys_rst;
        rd_done = req_r.valid & ~req_r.write & ~hready_r;
        hready_nxt = ~(acc & ~hwrite);
        c_rd_mask = c_rd;
        if (clk_en_r) begin
            c_rd_mask[gpio_abc_pkg::PC_CLK_PIN] = 1'b0;
        end
        case (req_r.idx)
            gpio_abc_pkg::IDX_PA_DATA: rd_mux = 32'(a_rd);
            gpio_abc_pkg::IDX_PB_DATA: rd_mux = 32'(b_rd);
            gpio_abc_pkg::IDX_PC_DATA: rd_mux = 32'(c_rd_mask);
            gpio_abc_pkg::IDX_PA_DIR:  rd_mux = 32'(a_dir);
            gpio_abc_pkg::IDX_PB_DIR:  rd_mux = 32'(b_dir);
            gpio_abc_pkg::IDX_PC_DIR:  rd_mux = 32'({clk_en_r, 1'b0, c_dir});
            default:                   rd_mux = '0;
        endcase
        hrdata_nxt = rd_done ? rd_mux : hrdata_r;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            req_r    <= '0;
            hready_r <= 1'b1;
            hrdata_r <= '0;
        end else begin
            req_r    <= req_nxt;
            hready_r <= hready_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = hready_r;
    assign hresp     = gpio_abc_pkg::HRESP_OKAY[0];

    // ************************************************
    // Clock output enable and divider
    // ************************************************
    always_comb begin
        clk_en_nxt = clk_en_r;
        if (wr_ok && req_r.idx == gpio_abc_pkg::IDX_PC_DIR) begin
            clk_en_nxt = hwdata[gpio_abc_pkg::CLK_EN_BIT];
        end
        clk_div_nxt = clk_en_nxt & ~clk_div_r;
        c_alt_en    = '0;
        c_alt_val   = '0;
        c_alt_en[gpio_abc_pkg::PC_CLK_PIN]  = clk_en_nxt;
        c_alt_val[gpio_abc_pkg::PC_CLK_PIN] = clk_div_nxt;
        b_hiz = '0;
        if (analog_chan_sel < gpio_abc_pkg::CHAN_COUNT) begin
            b_hiz[analog_chan_sel[2:0]] = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            clk_en_r  <= 1'b0;
            clk_div_r <= 1'b0;
        end else begin
            clk_en_r  <= clk_en_nxt;
            clk_div_r <= clk_div_nxt;
        end
    end

    // ************************************************
    // Ports
    // ************************************************
    port_slice #(.W(AW)) u_port_a (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .data_we    (wr_ok && req_r.idx == gpio_abc_pkg::IDX_PA_DATA),
        .dir_we     (wr_ok && req_r.idx == gpio_abc_pkg::IDX_PA_DIR),
        .wdata      (hwdata[AW-1:0]),
        .hiz_force  ('0),
        .alt_en     ('0),
        .alt_val    ('0),
        .pin_in     (pa_in),
        .pin_out_r  (pa_out),
        .pin_oe_n_r (pa_oe_n),
        .latch_r    (a_latch),
        .dir_r      (a_dir),
        .rd_val     (a_rd)
    );

    port_slice #(.W(BW)) u_port_b (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .data_we    (wr_ok && req_r.idx == gpio_abc_pkg::IDX_PB_DATA),
        .dir_we     (wr_ok && req_r.idx == gpio_abc_pkg::IDX_PB_DIR),
        .wdata      (hwdata[BW-1:0]),
        .hiz_force  (b_hiz),
        .alt_en     ('0),
        .alt_val    ('0),
        .pin_in     (pb_in),
        .pin_out_r  (pb_out),
        .pin_oe_n_r (pb_oe_n),
        .latch_r    (b_latch),
        .dir_r      (b_dir),
        .rd_val     (b_rd)
    );

    port_slice #(.W(CW)) u_port_c (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .data_we    (wr_ok && req_r.idx == gpio_abc_pkg::IDX_PC_DATA),
        .dir_we     (wr_ok && req_r.idx == gpio_abc_pkg::IDX_PC_DIR),
        .wdata      (hwdata[CW-1:0]),
        .hiz_force  ('0),
        .alt_en     (c_alt_en),
        .alt_val    (c_alt_val),
        .pin_in     (pc_in),
        .pin_out_r  (pc_out),
        .pin_oe_n_r (pc_oe_n),
        .latch_r    (c_latch),
        .dir_r      (c_dir),
        .rd_val     (c_rd)
    );

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    dir_reset_a: assert property (
        @(posedge core_clk) disable iff (1'b0) sys_rst |=> (a_dir == '0) && (b_dir == '0) && (&pa_oe_n))
        else $error("Port A/B direction not cleared by reset");

    pc_dir_reset_a: assert property (
        @(posedge core_clk) disable iff (1'b0) sys_rst |=> (c_dir == '0))
        else $error("Port C direction not cleared by reset");

    clk_en_reset_a: assert property (
        @(posedge core_clk) disable iff (1'b0) sys_rst |=> !clk_en_r && pc_oe_n[gpio_abc_pkg::PC_CLK_PIN])
        else $error("Clock output enable not cleared by reset");

    latch_keep_a: assert property (
        @(posedge core_clk) disable iff (1'b0)
        (!sys_rst ##1 sys_rst) |=> a_latch == $past(a_latch))
        else $error("Port A latch disturbed by reset");

    wr_latch_a: assert property (
        (wr_ok && req_r.idx == gpio_abc_pkg::IDX_PA_DATA) |=> a_latch == $past(hwdata[7:0]))
        else $error("Port A latch not written");

    oe_follow_a: assert property (
        (pa_oe_n == ~a_dir) && ((pa_out & a_dir) == (a_latch & a_dir)))
        else $error("Port A drive does not follow direction and latch");

    analog_hiz_a: assert property (
        (analog_chan_sel < gpio_abc_pkg::CHAN_COUNT) |=> pb_oe_n[$past(analog_chan_sel[2:0])])
        else $error("Analog-selected port B pin is driven");

    clk_out_a: assert property (
        clk_en_r && $past(clk_en_r) |-> !pc_oe_n[gpio_abc_pkg::PC_CLK_PIN]
            && (pc_out[gpio_abc_pkg::PC_CLK_PIN] != $past(pc_out[gpio_abc_pkg::PC_CLK_PIN])))
        else $error("Clock not driven on port C pin two");

    rd_mix_a: assert property (
        (rd_done && req_r.idx == gpio_abc_pkg::IDX_PA_DATA) |=>
            hrdata[7:0] == (($past(a_dir) & $past(a_latch)) | (~$past(a_dir) & $past(pa_in))))
        else $error("Port A readback mix wrong");

    in_read_a: assert property (
        (rd_done && req_r.idx == gpio_abc_pkg::IDX_PB_DATA && b_dir == '0) |=> hrdata[7:0] == $past(pb_in))
        else $error("Input pin readback not the pin level");

    pc_read_a: assert property (
        (rd_done && req_r.idx == gpio_abc_pkg::IDX_PC_DATA && !clk_en_r) |=>
            hrdata[5:0] == (($past(c_dir) & $past(c_latch)) | (~$past(c_dir) & $past(pc_in))))
        else $error("Port C readback mix wrong");

    pc_upper_a: assert property (
        (rd_done && req_r.idx == gpio_abc_pkg::IDX_PC_DATA) |=> hrdata[31:6] == '0)
        else $error("Port C upper bits not zero");

    rd_wait_a: assert property (
        (acc && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("Read wait state wrong");

    wr_rd_c: cover property ((acc && hwrite) ##1 (acc && !hwrite) ##2 hreadyout);
    clk_on_c: cover property (clk_en_r [*4]);
    analog_c: cover property ((analog_chan_sel < gpio_abc_pkg::CHAN_COUNT) && b_dir != '0);
    out_dir_c: cover property (a_dir != '0 && !rd_done ##1 rd_done);
endmodule : gpio_ports_abc

// *** src/port_slice.sv ***
// Purpose: One port: data latch, direction bits, pin drive and readback
// Assumes: Pin inputs synchronous to core_clk
// Notes:   Latch has no reset; direction and pin drive do

`timescale 1ns/1ns

module port_slice #(
    parameter int unsigned W = 8
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    // Register writes
    input  wire logic         data_we,
    input  wire logic         dir_we,
    input  wire logic [W-1:0] wdata,
    // Overrides
    input  wire logic [W-1:0] hiz_force,
    input  wire logic [W-1:0] alt_en,
    input  wire logic [W-1:0] alt_val,
    // Pins
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out_r,
    output logic      [W-1:0] pin_oe_n_r,
    // State
    output logic      [W-1:0] latch_r,
    output logic      [W-1:0] dir_r,
    output logic      [W-1:0] rd_val
);
    logic [W-1:0] latch_nxt;
    logic [W-1:0] dir_nxt;
    logic [W-1:0] pin_out_nxt;
    logic [W-1:0] pin_oe_n_nxt;

    // ************************************************
    // Next values
    // ************************************************
    always_comb begin
        latch_nxt    = data_we ? wdata : latch_r;
        dir_nxt      = dir_we ? wdata : dir_r;
        pin_out_nxt  = (alt_en & alt_val) | (~alt_en & latch_nxt);
        pin_oe_n_nxt = hiz_force | (~alt_en & ~dir_nxt);
        rd_val       = ((dir_r & ~hiz_force) & latch_r) | (~(dir_r & ~hiz_force) & pin_in);
    end

    // ************************************************
    // Latch: untouched by reset
    // ************************************************
    always_ff @(posedge core_clk) begin
        latch_r <= latch_nxt;
    end

    // ************************************************
    // Direction and pin drive
    // ************************************************
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dir_r      <= W'(gpio_abc_pkg::DIR_RESET);
            pin_out_r  <= W'(gpio_abc_pkg::DIR_RESET);
            pin_oe_n_r <= ~W'(gpio_abc_pkg::DIR_RESET);
        end else begin
            dir_r      <= dir_nxt;
            pin_out_r  <= pin_out_nxt;
            pin_oe_n_r <= pin_oe_n_nxt;
        end
    end
endmodule : port_slice

// *** verification/gpio_ports_abc_bench.sv ***
// Purpose: Self-checking bench for ports A, B and C
// Assumes: Far-side pads modelled by pin_far_side
// Notes:   Random values from a shift register seeded 32'h23f7

`timescale 1ns/1ns

module gpio_ports_abc_bench;
    logic        core_clk;
    logic        sys_rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [4:0]  analog_chan_sel;
    logic [4:0]  chan_req;
    logic [7:0]  pa_in, pa_out, pa_oe_n, pb_in, pb_out, pb_oe_n;
    logic [5:0]  pc_in, pc_out, pc_oe_n;
    logic [7:0]  lat [3];
    logic [7:0]  dir [3];
    logic [7:0]  ext [3];
    logic        clken;
    logic [31:0] rnd;
    logic [31:0] v;
    logic        b;
    int          miscompares;
    int          n_tests;
    localparam logic [7:0] MSK [3] = '{8'hff, 8'hff, 8'h3f};
    localparam logic [3:0] DIDX [3] = '{gpio_abc_pkg::IDX_PA_DATA, gpio_abc_pkg::IDX_PB_DATA,
                                        gpio_abc_pkg::IDX_PC_DATA};
    localparam logic [3:0] RIDX [3] = '{gpio_abc_pkg::IDX_PA_DIR, gpio_abc_pkg::IDX_PB_DIR,
                                        gpio_abc_pkg::IDX_PC_DIR};

    gpio_ports_abc u_gpio_ports_abc (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .analog_chan_sel(analog_chan_sel),
        .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pb_in(pb_in), .pb_out(pb_out),
        .pb_oe_n(pb_oe_n), .pc_in(pc_in), .pc_out(pc_out), .pc_oe_n(pc_oe_n));

    pin_far_side u_pin_far_side (.core_clk(core_clk), .pa_out(pa_out), .pa_oe_n(pa_oe_n),
        .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pc_out(pc_out), .pc_oe_n(pc_oe_n), .ext_a(ext[0]),
        .ext_b(ext[1]), .ext_c(ext[2][5:0]), .chan_req(chan_req), .pa_in(pa_in), .pb_in(pb_in),
        .pc_in(pc_in), .analog_chan_sel(analog_chan_sel));

    // ****************************************
    // Expectations
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0);
    endfunction : lfsr

    function automatic logic [7:0] eff_dir(input int p);
        eff_dir = dir[p] & MSK[p];
        if (p == 1 && chan_req < 5'h08) eff_dir[chan_req[2:0]] = 1'b0;
    endfunction : eff_dir

    function automatic logic [31:0] exp_data(input int p);
        logic [7:0] d;
        d = eff_dir(p);
        exp_data = {24'h0, ((d & lat[p]) | (~d & ext[p])) & MSK[p]};
        if (p == 2 && clken) exp_data[2] = 1'b0;
    endfunction : exp_data

    function automatic logic [31:0] exp_dir(input int p);
        exp_dir = {24'h0, dir[p]} | ((p == 2 && clken) ? 32'h80 : 32'h0);
    endfunction : exp_dir

    // ****************************************
    // Checks and bus cycles
    // ****************************************
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task end_of_test;
        if (miscompares == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    task wait_ready;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        wait_ready;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready;
        rd = hrdata;
        chk(hresp, 32'h0);
    endtask : bus

    task automatic wr_reg(input int p, input logic isdir, input logic [31:0] d);
        logic [31:0] t;
        bus(1'b1, {26'h0, isdir ? RIDX[p] : DIDX[p], 2'h0}, d, t);
        if (isdir) begin
            dir[p] = d[7:0] & MSK[p];
            if (p == 2) clken = d[7];
        end else begin
            lat[p] = d[7:0];
        end
    endtask : wr_reg

    task automatic rd(input int p, input logic isdir, output logic [31:0] r);
        bus(1'b0, {26'h0, isdir ? RIDX[p] : DIDX[p], 2'h0}, 32'h0, r);
    endtask : rd

    task automatic pin_chk(input int p);
        logic [7:0] d;
        logic [7:0] mo;
        #1;
        d = eff_dir(p);
        mo = (p == 2 && clken) ? 8'hfb : 8'hff;
        if (p == 2 && clken) d[2] = 1'b1;
        chk(p == 0 ? pa_oe_n : p == 1 ? pb_oe_n : {2'h0, pc_oe_n}, ~d & MSK[p]);
        chk((p == 0 ? pa_out : p == 1 ? pb_out : {2'h0, pc_out}) & d & mo, lat[p] & d & mo);
    endtask : pin_chk

    // ****************************************
    // Clock, watchdog, scenarios
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        end_of_test;
    end

    initial begin
        sys_rst = 1'b1;
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        chan_req = 5'h1f;
        ext = '{8'h0, 8'h0, 8'h0};
        dir = '{8'h0, 8'h0, 8'h0};
        clken = 1'b0;
        rnd = 32'h23f7;
        miscompares = 0;
        n_tests = 0;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        for (int p = 0; p < 3; p++) begin
            rd(p, 1'b1, v);
            chk(v, 32'h0);
            pin_chk(p);
            @(posedge core_clk);
            rnd = lfsr(rnd);
            ext[p] <= rnd[15:8];
            wr_reg(p, 1'b0, rnd);
            pin_chk(p);
            rd(p, 1'b0, v);
            chk(v, exp_data(p));
        end
        for (int i = 0; i < 30; i++) begin
            rnd = lfsr(rnd);
            wr_reg(i % 3, 1'b0, rnd);
            rnd = lfsr(rnd);
            wr_reg(i % 3, 1'b1, rnd);
            @(posedge core_clk);
            rnd = lfsr(rnd);
            ext[i % 3] <= rnd[7:0];
            rd(i % 3, 1'b0, v);
            chk(v, exp_data(i % 3));
            pin_chk(i % 3);
            rd(i % 3, 1'b1, v);
            chk(v, exp_dir(i % 3));
        end
        wr_reg(0, 1'b0, 32'h5a);
        wr_reg(0, 1'b1, 32'hff);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        dir = '{8'h0, 8'h0, 8'h0};
        clken = 1'b0;
        @(posedge core_clk);
        pin_chk(2);
        wr_reg(0, 1'b1, 32'hff);
        rd(0, 1'b0, v);
        chk(v, 32'h5a);
        wr_reg(1, 1'b1, 32'hff);
        for (int i = 0; i < 9; i++) begin
            @(posedge core_clk);
            chan_req <= i[4:0];
            ext[1] <= ~lat[1];
            repeat (3) @(posedge core_clk);
            pin_chk(1);
            rd(1, 1'b0, v);
            chk(v, exp_data(1));
        end
        wr_reg(2, 1'b0, 32'h3f);
        wr_reg(2, 1'b1, 32'hff);
        rd(2, 1'b1, v);
        chk(v, 32'hbf);
        rd(2, 1'b0, v);
        chk(v, exp_data(2));
        #1;
        b = pc_out[2];
        repeat (4) begin
            @(posedge core_clk);
            #1;
            chk(pc_oe_n[2], 1'b0);
            chk(pc_out[2], {31'h0, ~b});
            b = pc_out[2];
        end
        wr_reg(2, 1'b1, 32'h3f);
        pin_chk(2);
        bus(1'b1, 32'h40, 32'h0, v);
        bus(1'b1, 32'h0c, 32'hffff_ffff, v);
        bus(1'b0, 32'h0c, 32'h0, v);
        chk(v, 32'h0);
        rd(0, 1'b0, v);
        chk(v, exp_data(0));
        end_of_test;
    end
endmodule : gpio_ports_abc_bench

// *** verification/pin_far_side.sv ***
// Purpose: Far side of ports A, B, C: pads and converter select
// Assumes: Outside drive only reaches pins the block leaves high impedance
// Notes:   Converter select lags its request by one clock

`timescale 1ns/1ns

module pin_far_side (
    // Clock
    input  wire logic       core_clk,
    // Block drive
    input  wire logic [7:0] pa_out,
    input  wire logic [7:0] pa_oe_n,
    input  wire logic [7:0] pb_out,
    input  wire logic [7:0] pb_oe_n,
    input  wire logic [5:0] pc_out,
    input  wire logic [5:0] pc_oe_n,
    // Outside drive
    input  wire logic [7:0] ext_a,
    input  wire logic [7:0] ext_b,
    input  wire logic [5:0] ext_c,
    input  wire logic [4:0] chan_req,
    // Pin levels and converter select
    output logic      [7:0] pa_in,
    output logic      [7:0] pb_in,
    output logic      [5:0] pc_in,
    output logic      [4:0] analog_chan_sel = 5'h1f
);
    // Pad level: block drive where enabled, outside drive elsewhere
    assign pa_in = (pa_out & ~pa_oe_n) | (ext_a & pa_oe_n);
    assign pb_in = (pb_out & ~pb_oe_n) | (ext_b & pb_oe_n);
    assign pc_in = (pc_out & ~pc_oe_n) | (ext_c & pc_oe_n);

    always @(posedge core_clk) begin
        analog_chan_sel <= chan_req;
    end
endmodule : pin_far_side
